// File: core/host_serial_map.svh
`ifndef HOST_SERIAL_MAP_SVH
`define HOST_SERIAL_MAP_SVH
// Register indices; byte address is four times the index
`define RATE_IDX 8'h3B
`define TXDATA_IDX 8'h40
`define RXDATA_IDX 8'h41
`define STATUS_IDX 8'h42
// Rate register reset code
`define RATE_RESET 8'h7A
// Status bit positions
`define ST_TX_BUSY 0
`define ST_RX_FULL 1
`define ST_FRAME_ERR 2
`define ST_OVERRUN 3
// Divider constants and last data bit index
`define MANT_BIAS_SMALL 13'h0001
`define MANT_BIAS_LARGE 13'h0021
`define DATA_BITS 3'h7
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// File: core/host_serial_pkg.sv
package host_serial_pkg;
  // Rate register layout
  typedef struct packed {
    logic [2:0] rate_exponent;
    logic [4:0] rate_mantissa;
  } rate_t;
  // Sticky and live status flags
  typedef struct packed {
    logic overrun;
    logic frame_err;
    logic rx_full;
    logic tx_busy;
  } status_t;
  // Transmit sequencer
  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_START = 4'h2,
    TX_DATA = 4'h4,
    TX_STOP = 4'h8
  } tx_state_t;
  // Receive sequencer
  typedef enum logic [3:0] {
    RX_IDLE = 4'h1,
    RX_START = 4'h2,
    RX_DATA = 4'h4,
    RX_STOP = 4'h8
  } rx_state_t;
endpackage

// File: core/host_serial_baud_framing.sv
// How it works
// RULE1 - Exponent zero: rate is reference over mantissa+1
// RULE2 - Else reference over mantissa+33, over 2^(exponent-1)
// RULE3 - Frame is start, eight data, one stop
// RULE4 - No parity bit sent or checked
// RULE5 - Host keeps rate at most 1228.8 kbit/s
// RULE6 - Rate register read/write, resets to 7Ah
// RULE7 - Reset code 7Ah governs default speed
// RULE8 - Writing rate register changes rate at once
// RULE9 - Standard codes give the standard rates
// RULE10 - Idle high, LSB first, centre sampling
`timescale 1ns/10ps
`include "host_serial_map.svh"
module host_serial_baud_framing (
  // Clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  // 27.12 MHz reference pin
  input wire logic ref_clk,
  // Serial line pins
  input wire logic rxd,
  output logic txd,
  // AXI4-Lite write address
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // ----------------------------------------
  // Registers and state
  // ----------------------------------------
  host_serial_pkg::rate_t host_serial_rate; // Rate setting
  host_serial_pkg::status_t status; // Flags
  host_serial_pkg::tx_state_t tx_state; // Transmit state
  host_serial_pkg::rx_state_t rx_state; // Receive state
  logic [11:0] aw_addr; // Held write address
  logic aw_held; // Write address taken
  logic [31:0] w_data; // Held write data
  logic [3:0] w_strb; // Held write strobes
  logic w_held; // Write data taken
  logic [2:0] ref_sync; // Reference synchroniser and edge
  logic ref_tick; // One reference period elapsed
  logic rxd_meta; // First sync stage
  logic rxd_sync; // Second sync stage
  logic [12:0] divisor; // Reference periods per bit
  logic [12:0] tx_cnt; // Transmit bit timer
  logic [12:0] rx_cnt; // Receive bit timer
  logic [2:0] tx_bit; // Transmit bit index
  logic [2:0] rx_bit; // Receive bit index
  logic [7:0] tx_shift; // Transmit shifter
  logic [7:0] rx_shift; // Receive shifter
  logic [7:0] rx_data; // Last received byte
  logic do_write; // Register write this cycle
  logic tx_load; // Transmit data write accepted
  logic rx_read; // Receive data read taken
  logic clr_frame; // Software clears framing flag
  logic clr_overrun; // Software clears overrun flag
  logic rx_done; // Byte completed
  logic rx_bad; // Stop bit low
  logic tx_end; // Transmit bit timer expiry
  logic rx_end; // Receive bit timer expiry
  logic rx_half; // Receive half-bit expiry

  // ----------------------------------------
  // Bit rate divider
  // ----------------------------------------
  // Divisor from exponent and mantissa
  always_comb begin
    if (host_serial_rate.rate_exponent == 3'h0) begin
      divisor = {8'h00, host_serial_rate.rate_mantissa}
        + `MANT_BIAS_SMALL; // RULE1
    end else begin
      divisor = 13'(({8'h00, host_serial_rate.rate_mantissa}
        + `MANT_BIAS_LARGE)
        << (host_serial_rate.rate_exponent - 3'h1)); // RULE2
    end
  end

  // Reference pin synchronised, rising edge gives a tick
  always_ff @(posedge clk) begin
    if (rst) begin
      ref_sync <= 3'h0;
    end else if (ce) begin
      ref_sync <= {ref_sync[1:0], ref_clk};
    end
  end
  assign ref_tick = ref_sync[1] & ~ref_sync[2];

  // Timer expiries, divisor read live so a new rate acts at once
  assign tx_end = ref_tick && (tx_cnt >= divisor - 13'h0001); // RULE8
  assign rx_end = ref_tick && (rx_cnt >= divisor - 13'h0001);
  assign rx_half = ref_tick
    && (rx_cnt >= (divisor >> 1) - 13'h0001); // RULE10

  // ----------------------------------------
  // Register bus
  // ----------------------------------------
  // Write address channel
  always_ff @(posedge clk) begin
    if (rst) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
    end else if (ce) begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (do_write) begin
        aw_held <= 1'b0;
      end
    end
  end

  // Write data channel
  always_ff @(posedge clk) begin
    if (rst) begin
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (ce) begin
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (do_write) begin
        w_held <= 1'b0;
      end
    end
  end

  // Ready while nothing of that channel is held and no write response is pending
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
    end else if (ce) begin
      s_axi_awready <= ~aw_held & ~(s_axi_awvalid & s_axi_awready)
        & ~s_axi_bvalid;
      s_axi_wready <= ~w_held & ~(s_axi_wvalid & s_axi_wready)
        & ~s_axi_bvalid;
    end
  end

  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign tx_load = do_write && w_strb[0] && !status.tx_busy
    && aw_addr == {2'h0, `TXDATA_IDX, 2'h0};
  assign clr_frame = do_write && w_strb[0]
    && aw_addr == {2'h0, `STATUS_IDX, 2'h0} && w_data[`ST_FRAME_ERR];
  assign clr_overrun = do_write && w_strb[0]
    && aw_addr == {2'h0, `STATUS_IDX, 2'h0} && w_data[`ST_OVERRUN];

  // Write response, error on unmapped address
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (ce) begin
      if (do_write) begin
        s_axi_bvalid <= 1'b1;
        case (aw_addr)
          {2'h0, `RATE_IDX, 2'h0},
          {2'h0, `TXDATA_IDX, 2'h0},
          {2'h0, `RXDATA_IDX, 2'h0},
          {2'h0, `STATUS_IDX, 2'h0}: s_axi_bresp <= `RESP_OKAY;
          default: s_axi_bresp <= `RESP_SLVERR;
        endcase
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Rate register, reset code sets the default speed
  always_ff @(posedge clk) begin
    if (rst) begin
      host_serial_rate <= `RATE_RESET; // RULE6 RULE7 RULE9
    end else if (ce) begin
      if (do_write && w_strb[0]
          && aw_addr == {2'h0, `RATE_IDX, 2'h0}) begin
        host_serial_rate <= w_data[7:0]; // RULE6 RULE8
      end
    end
  end

  assign rx_read = s_axi_arvalid && s_axi_arready
    && s_axi_araddr == {2'h0, `RXDATA_IDX, 2'h0};

  // Read channel, one read at a time
  always_ff @(posedge clk) begin
    if (rst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ce) begin
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp <= `RESP_OKAY;
        case (s_axi_araddr)
          {2'h0, `RATE_IDX, 2'h0}:
            s_axi_rdata <= {24'h000000, host_serial_rate}; // RULE6
          {2'h0, `TXDATA_IDX, 2'h0}:
            s_axi_rdata <= {24'h000000, tx_shift};
          {2'h0, `RXDATA_IDX, 2'h0}:
            s_axi_rdata <= {24'h000000, rx_data};
          {2'h0, `STATUS_IDX, 2'h0}:
            s_axi_rdata <= {28'h0000000, status};
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid) begin
        if (s_axi_rready) begin
          s_axi_rvalid <= 1'b0;
        end
      end else begin
        s_axi_arready <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Transmitter
  // ----------------------------------------
  // Sequencer: start, eight data LSB first, stop, no parity
  always_ff @(posedge clk) begin
    if (rst) begin
      tx_state <= host_serial_pkg::TX_IDLE;
      txd <= 1'b1;
      tx_cnt <= 13'h0000;
      tx_bit <= 3'h0;
      tx_shift <= 8'h00;
    end else if (ce) begin
      if (ref_tick) begin
        tx_cnt <= tx_end ? 13'h0000 : tx_cnt + 13'h0001;
      end
      unique case (tx_state)
        host_serial_pkg::TX_IDLE: begin
          txd <= 1'b1; // RULE10
          if (tx_load) begin
            tx_shift <= w_data[7:0];
            tx_state <= host_serial_pkg::TX_START;
            txd <= 1'b0; // RULE3
            tx_cnt <= 13'h0000;
          end
        end
        host_serial_pkg::TX_START: begin
          if (tx_end) begin
            txd <= tx_shift[0]; // RULE10
            tx_bit <= 3'h0;
            tx_state <= host_serial_pkg::TX_DATA;
          end
        end
        host_serial_pkg::TX_DATA: begin
          if (tx_end) begin
            if (tx_bit == `DATA_BITS) begin
              txd <= 1'b1; // RULE3 RULE4
              tx_state <= host_serial_pkg::TX_STOP;
            end else begin
              tx_bit <= tx_bit + 3'h1;
              txd <= tx_shift[tx_bit + 3'h1];
            end
          end
        end
        host_serial_pkg::TX_STOP: begin
          if (tx_end) begin
            tx_state <= host_serial_pkg::TX_IDLE;
          end
        end
      endcase
    end
  end

  // ----------------------------------------
  // Receiver
  // ----------------------------------------
  // Line synchroniser
  always_ff @(posedge clk) begin
    if (rst) begin
      rxd_meta <= 1'b1;
      rxd_sync <= 1'b1;
    end else if (ce) begin
      rxd_meta <= rxd;
      rxd_sync <= rxd_meta;
    end
  end

  // Sequencer samples each bit at its centre
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_state <= host_serial_pkg::RX_IDLE;
      rx_cnt <= 13'h0000;
      rx_bit <= 3'h0;
      rx_shift <= 8'h00;
      rx_done <= 1'b0;
      rx_bad <= 1'b0;
    end else if (ce) begin
      rx_done <= 1'b0;
      rx_bad <= 1'b0;
      if (ref_tick) begin
        rx_cnt <= rx_cnt + 13'h0001;
      end
      unique case (rx_state)
        host_serial_pkg::RX_IDLE: begin
          rx_cnt <= 13'h0000;
          if (!rxd_sync) begin
            rx_state <= host_serial_pkg::RX_START;
          end
        end
        host_serial_pkg::RX_START: begin
          if (rx_half) begin
            rx_cnt <= 13'h0000;
            rx_bit <= 3'h0;
            // Glitch shorter than half a bit is dropped
            rx_state <= rxd_sync ? host_serial_pkg::RX_IDLE
              : host_serial_pkg::RX_DATA; // RULE10
          end
        end
        host_serial_pkg::RX_DATA: begin
          if (rx_end) begin
            rx_cnt <= 13'h0000;
            rx_shift <= {rxd_sync, rx_shift[7:1]}; // RULE10
            rx_bit <= rx_bit + 3'h1;
            if (rx_bit == `DATA_BITS) begin
              rx_state <= host_serial_pkg::RX_STOP; // RULE3 RULE4
            end
          end
        end
        host_serial_pkg::RX_STOP: begin
          if (rx_end) begin
            rx_done <= rxd_sync; // RULE3
            rx_bad <= ~rxd_sync;
            rx_state <= host_serial_pkg::RX_IDLE;
          end
        end
      endcase
    end
  end

  // Received byte and flags; a set wins over a clear
  always_ff @(posedge clk) begin
    if (rst) begin
      rx_data <= 8'h00;
      status <= 4'h0;
    end else if (ce) begin
      status.tx_busy <= (tx_state != host_serial_pkg::TX_IDLE)
        || tx_load;
      if (rx_done) begin
        rx_data <= rx_shift;
      end
      if (rx_done) begin
        status.rx_full <= 1'b1;
      end else if (rx_read) begin
        status.rx_full <= 1'b0;
      end
      if (rx_bad) begin
        status.frame_err <= 1'b1;
      end else if (clr_frame) begin
        status.frame_err <= 1'b0;
      end
      if (rx_done && status.rx_full && !rx_read) begin
        status.overrun <= 1'b1;
      end else if (clr_overrun) begin
        status.overrun <= 1'b0;
      end
    end
  end

endmodule // host_serial_baud_framing

// File: verification/host_serial_baud_framing_chk.sv
`timescale 1ns/10ps
// ------
// Checker
// ------
module host_serial_chk (
  // Clock, controls, line
  input wire logic clk, rst, ce, ref_clk, rxd, txd,
  // Bus payloads
  input wire logic [11:0] s_axi_awaddr, s_axi_araddr,
  input wire logic [31:0] s_axi_wdata, s_axi_rdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic [1:0] s_axi_bresp, s_axi_rresp,
  // Bus handshakes
  input wire logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready,
  input wire logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready,
  input wire logic s_axi_rvalid, s_axi_rready
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  logic hit; // Read address names a register
  logic wr_hs; // Address and data taken together
  logic rd_hs; // Read address taken
  assign hit = s_axi_araddr inside {12'h0EC, 12'h100, 12'h104, 12'h108};
  assign wr_hs = s_axi_awvalid && s_axi_awready
    && s_axi_wvalid && s_axi_wready;
  assign rd_hs = s_axi_arvalid && s_axi_arready;
  property p_rst;
    $fell(rst) |-> txd && !s_axi_bvalid && !s_axi_rvalid;
  endproperty
  a_rst: assert property (p_rst)
    else $error("not idle after reset");
  property p_bit; $changed(txd) |=> $stable(txd) [*7]; endproperty
  a_bit: assert property (p_bit)
    else $error("serial bit too short");
  property p_bhold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold)
    else $error("write response dropped");
  property p_rhold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold)
    else $error("read data dropped");
  property p_rlat; rd_hs |=> s_axi_rvalid && !s_axi_arready; endproperty
  a_rlat: assert property (p_rlat)
    else $error("read answer late");
  property p_wlat; wr_hs |-> ##2 s_axi_bvalid; endproperty
  a_wlat: assert property (p_wlat)
    else $error("write answer late");
  property p_err;
    rd_hs && !hit |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0;
  endproperty
  a_err: assert property (p_err)
    else $error("unmapped read not refused");
  property p_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_busy: assert property (p_busy)
    else $error("ready during response");
  c_tx: cover property ($fell(txd));
  c_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
  c_wr: cover property (s_axi_bvalid && s_axi_bready);
endmodule // host_serial_chk

bind host_serial_baud_framing host_serial_chk u_chk (.clk, .rst, .ce,
  .ref_clk, .rxd, .txd, .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata,
  .s_axi_rdata, .s_axi_wstrb, .s_axi_bresp, .s_axi_rresp, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready);

// File: verification/host_line_model.sv
`timescale 1ns/10ps
// ------
// Host end of the serial line
// ------
module host_line_model (
  // Launch clock
  input wire logic clk,
  // Line from device
  input wire logic txd,
  // Line to device
  output logic rxd
);
  real bit_ns = 811.36; // Bit time, set by the bench
  logic [8:0] got[$]; // Stop level and byte seen
  logic [7:0] sh; // Receive shift
  initial rxd = 1'b1;
  // Send start, byte LSB first, chosen stop level
  task automatic send(input logic [7:0] b, input logic stop);
    logic [9:0] f;
    f = {stop, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      @(posedge clk);
      rxd <= f[i];
      #(bit_ns);
    end
    @(posedge clk);
    rxd <= 1'b1;
  endtask
  // Catch a frame, sampling each bit mid-way
  always @(negedge txd) begin
    #(bit_ns * 1.5);
    for (int i = 0; i < 8; i++) begin
      sh[i] = txd;
      #(bit_ns);
    end
    got.push_back({txd, sh});
  end
endmodule // host_line_model

// File: verification/test_host_serial_baud_framing.sv
`timescale 1ns/10ps
// ------
// Bench
// ------
module test_host_serial_baud_framing;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, ref_clk = 1'b0; // Clocks
  logic rxd, txd; // Serial line
  logic [11:0] s_axi_awaddr = 12'h0, s_axi_araddr = 12'h0; // Addresses
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata; // Data
  logic [3:0] s_axi_wstrb = 4'hF; // Byte lanes
  logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid;
  int bad_count = 0; // Mismatches
  int n_checks = 0; // Comparisons
  int exp_q[$]; // Model of bytes due on the line
  logic [7:0] codes[4] = '{8'h15, 8'h1C, 8'h3A, 8'h5A};
  logic [31:0] d; // Read result
  logic [1:0] r; // Response
  logic [31:0] v; // Random value
  always #2.5 clk = ~clk;
  always #18.44 ref_clk = ~ref_clk; // Near 27.12 MHz
  host_serial_baud_framing u_dut (.clk, .rst, .ce, .ref_clk, .rxd, .txd,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  host_line_model u_host (.clk, .txd, .rxd);
  // Ticks per bit from a rate code
  function automatic int div_of(input logic [7:0] c);
    return (c[7:5] == 0) ? c[4:0] + 1 : (c[4:0] + 33) << (c[7:5] - 1);
  endfunction
  // Compare and tally
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      $display("ERROR %s expected %h seen %h", nm, e, g);
      bad_count++;
    end
  endtask
  // Bus write, address and data offered together
  task automatic axw(input logic [11:0] a, input logic [7:0] b,
                     output logic [1:0] rs);
    logic ka, kw;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, b};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // Flags remember which channel has been taken so far
    ka = 1'b0;
    kw = 1'b0;
    while (!(ka && kw)) begin
      @(negedge clk);
      ka = ka || s_axi_awready;
      kw = kw || s_axi_wready;
      @(posedge clk);
      if (ka) s_axi_awvalid <= 1'b0;
      if (kw) s_axi_wvalid <= 1'b0;
    end
    s_axi_bready <= 1'b1;
    do @(negedge clk); while (s_axi_bvalid !== 1'b1);
    rs = s_axi_bresp;
    @(posedge clk);
    s_axi_bready <= 1'b0;
  endtask
  // Bus read
  task automatic axr(input logic [11:0] a, output logic [31:0] dd,
                     output logic [1:0] rs);
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge clk); while (s_axi_arready !== 1'b1);
    @(posedge clk);
    s_axi_arvalid <= 1'b0;
    do @(negedge clk); while (s_axi_rvalid !== 1'b1);
    dd = s_axi_rdata;
    rs = s_axi_rresp;
    @(posedge clk);
    s_axi_rready <= 1'b0;
  endtask
  // Verdict and end of run
  task automatic final_report;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // Hang guard
  initial begin
    repeat (90000) @(posedge clk);
    bad_count++;
    final_report;
  end
  // Main sequence
  initial begin
    void'($urandom(32'h9192E43D));
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    axr(12'h0EC, d, r);
    chk("rate reset", 32'h7A, d);
    chk("rd ok", 32'h0, r);
    axw(12'h0F0, 8'hFF, r);
    chk("wr resp", 32'h2, r);
    axr(12'h0F0, d, r);
    chk("rd resp", 32'h2, r);
    v = $urandom;
    // Host keeps the rate within the supported range
    if (v[7:5] == 3'h0 && v[4:0] < 5'h15) v[4:0] = 5'h15;
    axw(12'h0EC, v[7:0], r);
    chk("wr ok", 32'h0, r);
    axr(12'h0EC, d, r);
    chk("rate rw", v[7:0], d);
    foreach (codes[i]) begin
      axw(12'h0EC, codes[i], r);
      u_host.bit_ns = div_of(codes[i]) * 36.88;
      v = $urandom;
      exp_q.push_back(v & 32'hFF);
      axw(12'h100, v[7:0], r);
      axr(12'h108, d, r);
      chk("tx busy", 32'h1, d & 32'h1);
      axr(12'h100, d, r);
      chk("tx hold", v[7:0], d);
      while (u_host.got.size() == 0) @(posedge clk);
      d = u_host.got.pop_front();
      chk("tx frame", 32'h100 + exp_q.pop_front(), d);
      v = $urandom;
      u_host.send(v[7:0], 1'b1);
      repeat (20) @(posedge clk);
      axr(12'h108, d, r);
      chk("rx full", 32'h2, d);
      axr(12'h104, d, r);
      chk("rx byte", v[7:0], d);
    end
    // Two bytes unread: the second overruns and replaces the first
    axw(12'h0EC, 8'h15, r);
    u_host.bit_ns = div_of(8'h15) * 36.88;
    u_host.send(8'h3C, 1'b1);
    u_host.send(8'hC3, 1'b1);
    repeat (20) @(posedge clk);
    axr(12'h108, d, r);
    chk("overrun", 32'hA, d & 32'hA);
    axr(12'h104, d, r);
    chk("rx last", 32'hC3, d);
    axw(12'h108, 8'h08, r);
    axr(12'h108, d, r);
    chk("ovr clear", 32'h0, d & 32'hA);
    u_host.send(8'hA5, 1'b0);
    repeat (20) @(posedge clk);
    axr(12'h108, d, r);
    chk("frame err", 32'h4, d & 32'h4);
    axw(12'h108, 8'h04, r);
    axr(12'h108, d, r);
    chk("err clear", 32'h0, d & 32'h4);
    final_report;
  end
endmodule // test_host_serial_baud_framing
